// ==== slo_regs.svh ====
// register offsets, field positions, reset values and codes for the strap and output-mode control
`ifndef SLO_REGS_SVH
`define SLO_REGS_SVH

`define SLO_OFF_CTRL       12'h000
`define SLO_OFF_REQ        12'h004
`define SLO_OFF_STATUS     12'h008
`define SLO_OFF_TEST       12'h00C

`define SLO_CTRL_DISP_SEL  0
`define SLO_CTRL_SE_SEL    1
`define SLO_CTRL_RST       32'h0000_0000

`define SLO_REQ_A_MODE     0
`define SLO_REQ_A_SEL      1
`define SLO_REQ_B_MODE     2
`define SLO_REQ_B_SEL      3
`define SLO_REQ_C_MODE     4
`define SLO_REQ_C_SEL      5
`define SLO_REQ_D_MODE     6
`define SLO_REQ_D_SEL      7
`define SLO_REQ_E_MODE     8
`define SLO_REQ_F_MODE     9
`define SLO_REQ_RST        32'h0000_0000

`define SLO_TEST_DIV_RST   8'h02

`define SLO_FS_100         3'h5
`define SLO_FS_133         3'h1
`define SLO_FS_166         3'h3
`define SLO_FS_200         3'h2
`define SLO_FS_266         3'h0
`define SLO_FS_333         3'h4
`define SLO_FS_400         3'h6
`define SLO_FS_RSVD        3'h7

`define SLO_MHZ_REF        16'd100
`define SLO_MHZ_DISP       16'd96

`endif

// ==== slo_pkg.sv ====
// types for the strap latch and output-mode control
package slo_pkg;
	typedef enum logic [1:0] {
		SLO_ST_WAIT = 2'b00,
		SLO_ST_RUN  = 2'b01,
		SLO_ST_PD   = 2'b11,
		SLO_ST_TEST = 2'b10
	} slo_state_t;
endpackage

// ==== slo_strap_ctrl.sv ====
// strap capture, power-down, stop/request pin handling and output-mode control
//
// Summary of operation
// - on power-good rising, latch frequency, debug, test and shared-pin straps
// - after latching, outside test operation, power-good pin low means power-down
// - extra-pair strap high: shared pins are clocks, else stop inputs
// - debug strap high: shared pair is debug clock, else reference pair
// - overclock-lock strap latched at power-up; only reported on overclock_locked and in status
// - cpu-stop input low stops cpu clocks, high runs them
// - pci-stop input low stops stoppable pci clocks, high runs them
// - request pins a and c low enable selected reference 0 or 2
// - request pins b and d low enable selected reference 1 or 4
// - request pin e low enables reference 6, high disables
// - request pin f low enables reference 8, high disables
// - request pin modes from registers; default pins are clock outputs
// - first pair carries reference 0 or 96 MHz display; default reference
// - second pair differential reference 1 or two single-ended clocks
// - test-select strap high at power-good enters test operation
// - test: mode high gives ref/N on outputs, low gives high impedance
// - latched frequency code sets cpu clock; 111 reserved
// - reference and display clocks fixed regardless
`timescale 1ns/100ps
`default_nettype none
`include "slo_regs.svh"

module slo_strap_ctrl (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        power_good_powerdown_pin,
	input  wire logic        freq_select_bit0,
	input  wire logic        freq_select_bit1,
	input  wire logic        freq_select_bit2,
	input  wire logic        extra_pair_enable_strap,
	input  wire logic        debug_port_clock_strap,
	input  wire logic        overclock_lock_strap,
	input  wire logic        test_select_strap,
	input  wire logic        test_mode_in,
	input  wire logic        cpu_stop_n,
	input  wire logic        pci_stop_n,
	input  wire logic        clk_request_a_n,
	input  wire logic        clk_request_b_n,
	input  wire logic        clk_request_c_n,
	input  wire logic        clk_request_d_n,
	input  wire logic        clk_request_e_n,
	input  wire logic        clk_request_f_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             powered_down,
	output logic             straps_valid,
	output logic      [2:0]  freq_select,
	output logic      [15:0] cpu_mhz,
	output logic             cpu_freq_reserved,
	output logic             overclock_locked,
	output logic             extra_pair_clock_mode,
	output logic             stop_inputs_mode,
	output logic             cpu_debug_clock,
	output logic             test_enable_latch,
	output logic             test_refdiv_out,
	output logic             test_hiz,
	output logic      [7:0]  test_div,
	output logic             cpu_clk_en,
	output logic             pci_stoppable_en,
	output logic      [8:0]  serial_ref_clock_en,
	output logic             display_96m_clock,
	output logic             single_ended_out1,
	output logic             single_ended_out2,
	output logic      [15:0] ref_mhz,
	output logic      [15:0] display_mhz
);

	slo_pkg::slo_state_t state;
	slo_pkg::slo_state_t next_state;
	logic        pg_q;
	logic        pg_rise;
	logic [31:0] ctrl;
	logic [31:0] req_cfg;
	logic        wr_en;
	logic        addr_ok;
	logic        run_st;
	logic        test_st;
	logic [8:0]  next_en_out;

	function automatic logic [15:0] fs_to_mhz(input logic [2:0] fs);
		case (fs)
			`SLO_FS_100: fs_to_mhz = 16'd100;
			`SLO_FS_133: fs_to_mhz = 16'd133;
			`SLO_FS_166: fs_to_mhz = 16'd166;
			`SLO_FS_200: fs_to_mhz = 16'd200;
			`SLO_FS_266: fs_to_mhz = 16'd266;
			`SLO_FS_333: fs_to_mhz = 16'd333;
			`SLO_FS_400: fs_to_mhz = 16'd400;
			default:     fs_to_mhz = 16'd0;
		endcase
	endfunction

	function automatic logic [3:0] ref_idx(input logic sel,
		input logic [3:0] lo, input logic [3:0] hi);
		ref_idx = sel ? hi : lo;
	endfunction

	assign pg_rise = power_good_powerdown_pin & ~pg_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pg_q <= 1'b0;
		end else if (clk_en) begin
			pg_q <= power_good_powerdown_pin;
		end
	end

	// strap capture only on power-good rising edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			freq_select           <= 3'h0;
			extra_pair_clock_mode <= 1'b0;
			cpu_debug_clock       <= 1'b0;
			overclock_locked      <= 1'b0;
			test_enable_latch     <= 1'b0;
			straps_valid          <= 1'b0;
		end else if (clk_en && pg_rise) begin
			freq_select           <= {freq_select_bit2, freq_select_bit1,
				freq_select_bit0};
			extra_pair_clock_mode <= extra_pair_enable_strap;
			cpu_debug_clock       <= debug_port_clock_strap;
			overclock_locked      <= overclock_lock_strap;
			test_enable_latch     <= test_select_strap;
			straps_valid          <= 1'b1;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			slo_pkg::SLO_ST_WAIT: begin
				if (pg_rise) begin
					next_state = test_select_strap ? slo_pkg::SLO_ST_TEST
						: slo_pkg::SLO_ST_RUN;
				end
			end
			slo_pkg::SLO_ST_RUN: begin
				if (!power_good_powerdown_pin) begin
					next_state = slo_pkg::SLO_ST_PD;
				end
			end
			slo_pkg::SLO_ST_PD: begin
				if (power_good_powerdown_pin) begin
					next_state = test_select_strap ? slo_pkg::SLO_ST_TEST
						: slo_pkg::SLO_ST_RUN;
				end
			end
			slo_pkg::SLO_ST_TEST: begin
				next_state = slo_pkg::SLO_ST_TEST;
			end
			default: next_state = slo_pkg::SLO_ST_WAIT;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= slo_pkg::SLO_ST_WAIT;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// apb slave, zero wait states
	assign pready  = 1'b1;
	assign addr_ok = (paddr == `SLO_OFF_CTRL) || (paddr == `SLO_OFF_REQ)
		|| (paddr == `SLO_OFF_STATUS) || (paddr == `SLO_OFF_TEST);
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en   = clk_en & psel & penable & pwrite;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl     <= `SLO_CTRL_RST;
			req_cfg  <= `SLO_REQ_RST;
			test_div <= `SLO_TEST_DIV_RST;
		end else if (wr_en) begin
			case (paddr)
				`SLO_OFF_CTRL: ctrl <= pwdata & 32'h0000_0003;
				`SLO_OFF_REQ:  req_cfg <= pwdata & 32'h0000_03FF;
				`SLO_OFF_TEST: test_div <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && psel && !penable && !pwrite) begin
			case (paddr)
				`SLO_OFF_CTRL:   prdata <= ctrl;
				`SLO_OFF_REQ:    prdata <= req_cfg;
				`SLO_OFF_STATUS: prdata <= {22'h0, state, straps_valid,
					test_enable_latch, overclock_locked, cpu_debug_clock,
					extra_pair_clock_mode, freq_select};
				`SLO_OFF_TEST:   prdata <= {24'h0, test_div};
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end

	// output modes and gating
	assign run_st  = (state == slo_pkg::SLO_ST_RUN);
	assign test_st = (state == slo_pkg::SLO_ST_TEST);

	always_comb begin
		logic [8:0] en;
		en = {9{run_st}};
		// request pins in request mode gate their selected outputs
		if (req_cfg[`SLO_REQ_A_MODE] && clk_request_a_n) begin
			en[ref_idx(req_cfg[`SLO_REQ_A_SEL], 4'h0, 4'h2)] = 1'b0;
		end
		if (req_cfg[`SLO_REQ_C_MODE] && clk_request_c_n) begin
			en[ref_idx(req_cfg[`SLO_REQ_C_SEL], 4'h0, 4'h2)] = 1'b0;
		end
		if (req_cfg[`SLO_REQ_B_MODE] && clk_request_b_n) begin
			en[ref_idx(req_cfg[`SLO_REQ_B_SEL], 4'h1, 4'h4)] = 1'b0;
		end
		if (req_cfg[`SLO_REQ_D_MODE] && clk_request_d_n) begin
			en[ref_idx(req_cfg[`SLO_REQ_D_SEL], 4'h1, 4'h4)] = 1'b0;
		end
		if (req_cfg[`SLO_REQ_E_MODE] && clk_request_e_n) begin
			en[6] = 1'b0;
		end
		if (req_cfg[`SLO_REQ_F_MODE] && clk_request_f_n) begin
			en[8] = 1'b0;
		end
		// pins used as request inputs carry no clock
		if (req_cfg[`SLO_REQ_C_MODE] || req_cfg[`SLO_REQ_D_MODE]) begin
			en[3] = 1'b0;
		end
		if (req_cfg[`SLO_REQ_E_MODE] || req_cfg[`SLO_REQ_F_MODE]) begin
			en[7] = 1'b0;
		end
		if (!extra_pair_clock_mode) begin
			en[5] = 1'b0;
		end
		if (cpu_debug_clock) begin
			en[8] = 1'b0;
		end
		if (ctrl[`SLO_CTRL_DISP_SEL]) begin
			en[0] = 1'b0;
		end
		if (ctrl[`SLO_CTRL_SE_SEL]) begin
			en[1] = 1'b0;
		end
		next_en_out = en;
	end

	// reference output enables
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serial_ref_clock_en <= 9'h000;
		end else if (clk_en) begin
			serial_ref_clock_en <= next_en_out;
		end
	end

	// role of the shared stop pins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stop_inputs_mode <= 1'b0;
		end else if (clk_en) begin
			stop_inputs_mode <= straps_valid & ~extra_pair_clock_mode;
		end
	end

	// stop inputs gate only while the shared pins are inputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_clk_en       <= 1'b0;
			pci_stoppable_en <= 1'b0;
		end else if (clk_en) begin
			cpu_clk_en       <= run_st
				& (extra_pair_clock_mode | cpu_stop_n);
			pci_stoppable_en <= run_st
				& (extra_pair_clock_mode | pci_stop_n);
		end
	end

	// pair modes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			display_96m_clock <= 1'b0;
			single_ended_out1 <= 1'b0;
			single_ended_out2 <= 1'b0;
		end else if (clk_en) begin
			display_96m_clock <= run_st
				& ctrl[`SLO_CTRL_DISP_SEL];
			single_ended_out1 <= run_st
				& ctrl[`SLO_CTRL_SE_SEL];
			single_ended_out2 <= run_st
				& ctrl[`SLO_CTRL_SE_SEL];
		end
	end

	// power-down indication
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			powered_down <= 1'b0;
		end else if (clk_en) begin
			powered_down <= (state == slo_pkg::SLO_ST_PD);
		end
	end

	// test clock operation
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			test_refdiv_out <= 1'b0;
			test_hiz        <= 1'b0;
		end else if (clk_en) begin
			test_refdiv_out <= test_st & test_mode_in;
			test_hiz        <= test_st & ~test_mode_in;
		end
	end

	// cpu frequency from the latched code
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_freq_reserved <= 1'b0;
			cpu_mhz           <= 16'd0;
		end else if (clk_en) begin
			cpu_freq_reserved <= straps_valid
				& (freq_select == `SLO_FS_RSVD);
			cpu_mhz           <= fs_to_mhz(freq_select);
		end
	end

	// fixed-frequency domains
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ref_mhz     <= 16'd0;
			display_mhz <= 16'd0;
		end else if (clk_en) begin
			ref_mhz     <= `SLO_MHZ_REF;
			display_mhz <= `SLO_MHZ_DISP;
		end
	end

endmodule // slo_strap_ctrl
`default_nettype wire

// ==== slo_board_model.sv ====
// board straps and system stop/request logic facing the strap control
`timescale 1ns/100ps
`default_nettype none
module slo_board_model (
	input  wire logic       mclk,
	input  wire logic       pg_cmd,
	input  wire logic [6:0] strap_set,
	input  wire logic [7:0] ctl_set_n,
	output logic            pg_pin,
	output logic      [6:0] strap_pin,
	output logic      [7:0] ctl_pin_n
);
	logic [1:0] age;
	always_ff @(posedge mclk) begin
		age <= !pg_pin ? 2'h0 : (age == 2'h3) ? age : age + 2'h1;
	end
	assign pg_pin = pg_cmd;
	// shared pins turn into clock outputs after capture
	assign strap_pin = (age == 2'h3) ? ~strap_set : strap_set;
	assign ctl_pin_n = ctl_set_n;
endmodule // slo_board_model
`default_nettype wire

// ==== slo_strap_ctrl_checker.sv ====
// port assertions for the strap latch and output-mode control
`timescale 1ns/100ps
`default_nettype none
module slo_strap_ctrl_checker (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        power_good_powerdown_pin,
	input wire logic        cpu_stop_n,
	input wire logic        pci_stop_n,
	input wire logic        test_mode_in,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        powered_down,
	input wire logic        straps_valid,
	input wire logic [2:0]  freq_select,
	input wire logic        overclock_locked,
	input wire logic        extra_pair_clock_mode,
	input wire logic        stop_inputs_mode,
	input wire logic        test_enable_latch,
	input wire logic        test_refdiv_out,
	input wire logic        test_hiz,
	input wire logic        cpu_clk_en,
	input wire logic        pci_stoppable_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n || !clk_en);
	pd_entry_a: assert property (straps_valid && !test_enable_latch &&
		!power_good_powerdown_pin |-> ##[1:2] powered_down)
		else $error("power-down not entered");
	mode_excl_a: assert property ($past(straps_valid)
		|-> stop_inputs_mode != $past(extra_pair_clock_mode))
		else $error("shared pin mode conflict");
	strap_hold_a: assert property (straps_valid && power_good_powerdown_pin
		&& $past(power_good_powerdown_pin) && $past(power_good_powerdown_pin, 2)
		|=> $stable(freq_select) && $stable(overclock_locked))
		else $error("latched strap changed");
	cpu_stop_a: assert property (stop_inputs_mode && !cpu_stop_n
		|=> !cpu_clk_en) else $error("cpu clock not stopped");
	pci_stop_a: assert property (stop_inputs_mode && !pci_stop_n
		|=> !pci_stoppable_en) else $error("pci clock not stopped");
	test_div_a: assert property (test_enable_latch && test_mode_in
		|=> test_refdiv_out && !test_hiz) else $error("no divided output");
	test_hiz_a: assert property (test_enable_latch && !test_mode_in
		|=> test_hiz && !test_refdiv_out) else $error("no high impedance");
	bad_addr_a: assert property (psel && penable && paddr > 12'h00C
		|-> pslverr && pready) else $error("unmapped access not flagged");
	cover property (powered_down);
	cover property (test_enable_latch && test_refdiv_out);
	cover property (stop_inputs_mode && !cpu_clk_en);
endmodule // slo_strap_ctrl_checker
bind slo_strap_ctrl slo_strap_ctrl_checker chk_u (.*);
`default_nettype wire

// ==== slo_strap_ctrl_test.sv ====
// self-checking bench for the strap latch and output-mode control
`timescale 1ns/100ps
`default_nettype none
module slo_strap_ctrl_test;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pg = 1'b0;
	logic        test_mode_in = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [6:0]  st = 7'h00;
	logic [7:0]  ctl = 8'hFF;
	logic        pgp, er, pready, pslverr, powered_down, straps_valid;
	logic [6:0]  sp;
	logic [7:0]  cp, test_div;
	logic [31:0] rd, prdata;
	logic [15:0] cpu_mhz, ref_mhz, display_mhz;
	logic [8:0]  serial_ref_clock_en;
	logic [3:0]  rq;
	logic [2:0]  freq_select;
	logic        cpu_freq_reserved, overclock_locked, extra_pair_clock_mode;
	logic        stop_inputs_mode, cpu_debug_clock, test_enable_latch;
	logic        test_refdiv_out, test_hiz, cpu_clk_en, pci_stoppable_en;
	logic        display_96m_clock, single_ended_out1, single_ended_out2;
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [15:0] mhz [8] = '{16'h010A, 16'h0085, 16'h00C8, 16'h00A6,
		16'h014D, 16'h0064, 16'h0190, 16'h0000};
	assign rq = {serial_ref_clock_en[8], serial_ref_clock_en[6],
		serial_ref_clock_en[4], serial_ref_clock_en[0]};
	slo_board_model brd_u (.mclk(mclk), .pg_cmd(pg), .strap_set(st),
		.ctl_set_n(ctl), .pg_pin(pgp), .strap_pin(sp), .ctl_pin_n(cp));
	slo_strap_ctrl dut_u (.*, .clk_en(1'b1), .power_good_powerdown_pin(pgp),
		.freq_select_bit0(sp[0]), .freq_select_bit1(sp[1]),
		.freq_select_bit2(sp[2]), .extra_pair_enable_strap(sp[3]),
		.debug_port_clock_strap(sp[4]), .overclock_lock_strap(sp[5]),
		.test_select_strap(sp[6]), .cpu_stop_n(cp[0]), .pci_stop_n(cp[1]),
		.clk_request_a_n(cp[2]), .clk_request_b_n(cp[3]),
		.clk_request_c_n(cp[4]), .clk_request_d_n(cp[5]),
		.clk_request_e_n(cp[6]), .clk_request_f_n(cp[7]));
	always #12.5 mclk = ~mclk;
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk) penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic pwr(input logic [6:0] s);
		pg <= 1'b0;
		st <= s;
		repeat (3) @(posedge mclk);
		if (straps_valid === 1'b1)
			chk(powered_down, 1'b1);
		pg <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, 12'h010, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		for (int i = 0; i < 8; i++) begin
			pwr({1'b0, i[0], i[1], ~i[0], i[2:0]});
			chk(freq_select, i[2:0]);
			chk(cpu_mhz, mhz[i]);
			chk(cpu_freq_reserved, i == 7);
			chk({extra_pair_clock_mode, stop_inputs_mode}, {!i[0], i[0]});
			chk(cpu_debug_clock, i[1]);
			chk(overclock_locked, i[0]);
			chk({serial_ref_clock_en[8], serial_ref_clock_en[5]}, {!i[1], !i[0]});
			chk({ref_mhz, display_mhz}, 32'h0064_0060);
			if (i == 5) begin
				ctl <= 8'hFE;
				repeat (2) @(posedge mclk);
				chk(cpu_clk_en, 1'b0);
				ctl <= 8'hFD;
				repeat (2) @(posedge mclk);
				chk({cpu_clk_en, pci_stoppable_en}, 2'b10);
				ctl <= 8'hFF;
			end
		end
		pwr(7'h08);
		apb(1'b1, 12'h004, 32'h0000_030D);
		chk(rq, 4'h0);
		chk(serial_ref_clock_en, 9'h02E);
		ctl <= 8'h33;
		repeat (2) @(posedge mclk);
		chk(rq, 4'hF);
		chk(serial_ref_clock_en, 9'h17F);
		apb(1'b1, 12'h000, 32'h0000_0003);
		chk({display_96m_clock, single_ended_out1}, 2'b11);
		chk(single_ended_out2, 1'b1);
		chk(serial_ref_clock_en, 9'h17C);
		apb(1'b1, 12'h004, 32'h0000_0070);
		chk(serial_ref_clock_en, 9'h1F0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0000_0070);
		ctl <= 8'h03;
		repeat (2) @(posedge mclk);
		chk(serial_ref_clock_en, 9'h1F4);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		pwr(7'h40);
		chk(test_enable_latch, 1'b1);
		test_mode_in <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({test_refdiv_out, test_hiz}, 2'b10);
		test_mode_in <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({test_refdiv_out, test_hiz}, 2'b01);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h0000_02C0);
		apb(1'b1, 12'h00C, 32'h0000_0105);
		chk(test_div, 32'h0000_0005);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0000_0005);
		test_done();
	end
endmodule // slo_strap_ctrl_test
`default_nettype wire
